// [front_panel_led.v]
// Front-panel port, health and hot-swap indicator logic with APB registers
`timescale 1ns/100ps
`include "panel_led_defs.vh"
module front_panel_led #(
   parameter NPORT         = 26,
   parameter NGIG          = 2,
   parameter DEBOUNCE_CYC  = `DEBOUNCE_CYC,
   parameter BLINK_CYC     = `BLINK_CYC,
   parameter SELFTEST_CYC  = `SELFTEST_CYC,
   parameter LAMP_TEST_CYC = `LAMP_TEST_CYC,
   parameter STP_HOLD_CYC  = `STP_HOLD_CYC
) (
   // Clock, enable and reset
   input  wire               clk_sys_i,
   input  wire               ce_i,
   input  wire               srst_i,
   // APB slave
   input  wire               psel_i,
   input  wire               penable_i,
   input  wire               pwrite_i,
   input  wire [11:0]        paddr_i,
   input  wire [31:0]        pwdata_i,
   output reg  [31:0]        prdata_o,
   output reg                pready_o,
   output reg                pslverr_o,
   // Port status
   input  wire [NPORT-1:0]   link_up_i,
   input  wire [NPORT-1:0]   activity_i,
   input  wire [NPORT-1:0]   forwarding_i,
   input  wire [NPORT-1:0]   reconfig_i,
   input  wire [2*NPORT-1:0] speed_i,
   // Board state
   input  wire               button_i,
   input  wire               ejector_partial_i,
   input  wire               shutdown_done_i,
   input  wire               over_temp_i,
   input  wire               volt_fault_i,
   input  wire               mgmt_timeout_i,
   // Lamps, removal request and interrupt
   output reg  [NPORT-1:0]   port_green_o,
   output reg  [NPORT-1:0]   port_amber_o,
   output reg                health_green_o,
   output reg                health_amber_o,
   output reg                hotswap_blue_o,
   output reg                remove_req_o,
   output reg                irq_o
);
   localparam HS_ACTIVE = 2'd0;
   localparam HS_WAIT   = 2'd1;
   localparam HS_SAFE   = 2'd2;

   function speed_is;
      input [2*NPORT-1:0] spd;
      input integer       p;
      input [1:0]         code;
      begin
         speed_is = (spd[2*p +: 2] == code);
      end
   endfunction

   function [31:0] inc_wrap;
      input [31:0] v;
      input [31:0] lim;
      begin
         inc_wrap = (v >= lim - 32'd1) ? 32'd0 : v + 32'd1;
      end
   endfunction

   reg  [1:0]       ctrl;
   reg  [`IRQ_WIDTH-1:0] irq_stat;
   reg  [`IRQ_WIDTH-1:0] irq_mask;
   reg  [NPORT-1:0] fwd_force;
   reg              btn_s1;
   reg              btn_s2;
   reg              btn_db;
   reg  [31:0]      db_cnt;
   reg              mode_speed;
   reg  [31:0]      blink_cnt;
   reg              blink;
   reg  [31:0]      st_cnt;
   reg              st_blink;
   reg  [31:0]      lamp_cnt;
   reg              lamp_test;
   reg  [63:0]      hold_cnt [0:NPORT-1];
   reg  [NPORT-1:0] hold;
   reg  [1:0]       hs_state;
   reg              fault_q;
   reg  [NPORT-1:0] next_green;
   reg  [NPORT-1:0] next_amber;
   reg  [`IRQ_WIDTH-1:0] ev;
   reg  [`IRQ_WIDTH-1:0] next_irq_stat;
   wire             fault = over_temp_i | volt_fault_i | mgmt_timeout_i;
   wire             acc = psel_i & penable_i & ~pready_o;
   wire             rd_stat = acc & ~pwrite_i & (paddr_i == `REG_IRQ_STAT);
   wire             db_done = (db_cnt >= DEBOUNCE_CYC - 1);
   wire             db_press = db_done & (btn_s2 != btn_db) & btn_s2;
   integer          i;
   integer          j;

   // Button synchroniser and debounce; rising press toggles once
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         btn_s1     <= 1'b0;
         btn_s2     <= 1'b0;
         btn_db     <= 1'b0;
         db_cnt     <= 32'd0;
         mode_speed <= 1'b0;
      end else if (ce_i) begin
         btn_s1 <= button_i;
         btn_s2 <= btn_s1;
         if (btn_s2 == btn_db)
            db_cnt <= 32'd0;
         else if (!db_done)
            db_cnt <= db_cnt + 32'd1;
         else begin
            db_cnt <= 32'd0;
            btn_db <= btn_s2;
         end
         if (db_press)
            mode_speed <= ~mode_speed;
         else if (acc && pwrite_i && paddr_i == `REG_CTRL)
            mode_speed <= pwdata_i[`CTRL_MODE_BIT];
      end
   end

   // Blink timers, lamp test at power-on
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         blink_cnt <= 32'd0;
         blink     <= 1'b0;
         st_cnt    <= 32'd0;
         st_blink  <= 1'b0;
         lamp_cnt  <= 32'd0;
         lamp_test <= 1'b1;
      end else if (ce_i) begin
         blink_cnt <= inc_wrap(blink_cnt, BLINK_CYC);
         if (blink_cnt == BLINK_CYC - 1)
            blink <= ~blink;
         st_cnt <= inc_wrap(st_cnt, SELFTEST_CYC);
         if (st_cnt == SELFTEST_CYC - 1)
            st_blink <= ~st_blink;
         if (lamp_test) begin
            lamp_cnt <= lamp_cnt + 32'd1;
            if (lamp_cnt == LAMP_TEST_CYC - 1)
               lamp_test <= 1'b0;
         end
      end
   end

   // Amber hold after reconfiguration, bounded by the loop-check time
   always @(posedge clk_sys_i) begin
      for (i = 0; i < NPORT; i = i + 1) begin
         if (srst_i) begin
            hold_cnt[i] <= 64'd0;
            hold[i]     <= 1'b0;
         end else if (ce_i) begin
            if (reconfig_i[i]) begin
               hold_cnt[i] <= 64'd0;
               hold[i]     <= 1'b1;
            end else if (hold[i]) begin
               hold_cnt[i] <= hold_cnt[i] + 64'd1;
               if (hold_cnt[i] >= STP_HOLD_CYC - 1 || forwarding_i[i])
                  hold[i] <= 1'b0;
            end
         end
      end
   end

   // Port lamp colour per view
   always @* begin
      next_green = {NPORT{1'b0}};
      next_amber = {NPORT{1'b0}};
      for (j = 0; j < NPORT; j = j + 1) begin
         if (lamp_test) begin
            next_green[j] = blink;
         end else if (mode_speed) begin
            if (j >= NPORT - NGIG) begin
               next_green[j] = link_up_i[j] &
                  speed_is(speed_i, j, `SPD_100);
               next_amber[j] = link_up_i[j] &
                  speed_is(speed_i, j, `SPD_1000);
            end else begin
               next_green[j] = link_up_i[j] &
                  ~speed_is(speed_i, j, `SPD_10);
            end
         end else if (link_up_i[j]) begin
            if (!forwarding_i[j] || fwd_force[j] || hold[j])
               next_amber[j] = 1'b1;
            else if (activity_i[j])
               next_green[j] = blink;
            else
               next_green[j] = 1'b1;
         end
      end
   end

   // Interrupt events; a new event in the clearing read's cycle survives
   always @* begin
      ev = {`IRQ_WIDTH{1'b0}};
      ev[`IRQ_MODE_BIT]   = db_press;
      ev[`IRQ_REMOVE_BIT] = (hs_state == HS_ACTIVE) & ejector_partial_i;
      ev[`IRQ_FAULT_BIT]  = fault & ~fault_q;
      ev[`IRQ_SAFE_BIT]   = (hs_state == HS_WAIT) & ejector_partial_i &
                            shutdown_done_i;
      next_irq_stat = (rd_stat ? {`IRQ_WIDTH{1'b0}} : irq_stat) | ev;
   end

   // Port lamps
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         port_green_o <= {NPORT{1'b0}};
         port_amber_o <= {NPORT{1'b0}};
      end else if (ce_i) begin
         port_green_o <= next_green;
         port_amber_o <= next_amber;
      end
   end

   // Health lamp; a fault overrides the self-test blink
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         health_green_o <= 1'b0;
         health_amber_o <= 1'b0;
         fault_q        <= 1'b0;
      end else if (ce_i) begin
         fault_q <= fault;
         if (lamp_test) begin
            health_green_o <= blink;
            health_amber_o <= 1'b0;
         end else if (fault) begin
            health_green_o <= 1'b0;
            health_amber_o <= 1'b1;
         end else begin
            health_green_o <= ctrl[`CTRL_READY_BIT] | st_blink;
            health_amber_o <= 1'b0;
         end
      end
   end

   // Hot-swap sequence
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         hotswap_blue_o <= 1'b0;
         remove_req_o   <= 1'b0;
         hs_state       <= HS_ACTIVE;
      end else if (ce_i) begin
         case (hs_state)
            HS_ACTIVE: begin
               if (ejector_partial_i) begin
                  hs_state     <= HS_WAIT;
                  remove_req_o <= 1'b1;
               end
            end
            HS_WAIT: begin
               if (!ejector_partial_i) begin
                  hs_state     <= HS_ACTIVE;
                  remove_req_o <= 1'b0;
               end else if (shutdown_done_i)
                  hs_state <= HS_SAFE;
            end
            HS_SAFE: begin
               if (!ejector_partial_i) begin
                  hs_state     <= HS_ACTIVE;
                  remove_req_o <= 1'b0;
               end
            end
            default: hs_state <= HS_ACTIVE;
         endcase
         hotswap_blue_o <= lamp_test ? blink :
                           (hs_state == HS_SAFE);
      end
   end

   // Sticky interrupt status and level output
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         irq_stat <= {`IRQ_WIDTH{1'b0}};
         irq_o    <= 1'b0;
      end else if (ce_i) begin
         irq_stat <= next_irq_stat;
         irq_o    <= |(next_irq_stat & irq_mask);
      end
   end

   // APB slave: one wait state, unmapped reads zero with an error
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         ctrl      <= `CTRL_RESET;
         irq_mask  <= `IRQ_MASK_RESET;
         fwd_force <= {NPORT{1'b0}};
         prdata_o  <= 32'h00000000;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end else if (ce_i) begin
         pready_o  <= acc;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h00000000;
         if (acc) begin
            case (paddr_i)
               `REG_CTRL: begin
                  if (pwrite_i)
                     ctrl <= pwdata_i[1:0];
                  prdata_o <= {30'h0, ctrl[`CTRL_READY_BIT], mode_speed};
               end
               `REG_STATUS:
                  prdata_o <= {25'h0, hs_state, fault, lamp_test,
                               remove_req_o, hotswap_blue_o, mode_speed};
               `REG_IRQ_STAT:
                  prdata_o <= {28'h0, irq_stat};
               `REG_IRQ_MASK: begin
                  if (pwrite_i)
                     irq_mask <= pwdata_i[`IRQ_WIDTH-1:0];
                  prdata_o <= {28'h0, irq_mask};
               end
               `REG_PORT_FWD: begin
                  if (pwrite_i)
                     fwd_force <= pwdata_i[NPORT-1:0];
                  prdata_o <= {{(32-NPORT){1'b0}}, fwd_force};
               end
               default:
                  pslverr_o <= 1'b1;
            endcase
         end
      end
   end
endmodule // front_panel_led

// [front_panel_led_checker.sv]
// Assertion checker for the front-panel indicator block
`timescale 1ns/100ps
module front_panel_led_checker #(
   parameter LAMP_TEST_CYC = 16
) (
   input wire        clk_sys_i, ce_i, srst_i, psel_i, penable_i,
   input wire [31:0] prdata_o,
   input wire        pready_o, pslverr_o, ejector_partial_i,
   input wire        over_temp_i, volt_fault_i, mgmt_timeout_i,
   input wire [25:0] link_up_i, forwarding_i, port_green_o, port_amber_o,
   input wire        health_green_o, health_amber_o, hotswap_blue_o, irq_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   // Cycles since reset; lamp rules other than a_lamp_amber_off only hold once the lamp test is over
   int cnt = 0;
   always @(posedge clk_sys_i)
      cnt <= srst_i ? 0 : (cnt < 99 ? cnt + 1 : cnt);
   wire live = cnt > LAMP_TEST_CYC + 3;
   sequence s_access; psel_i && penable_i && !pready_o && ce_i; endsequence
   sequence s_answer; pready_o ##1 !pready_o; endsequence
   a_ready_one_wait: assert property (s_access |=> s_answer)
      else $error("pready not a one-cycle answer");
   a_err_read_zero: assert property (pslverr_o |-> pready_o && !prdata_o)
      else $error("error response malformed");
   a_reset_quiet: assert property (disable iff (1'b0)
      srst_i |=> !pready_o && !irq_o && !hotswap_blue_o)
      else $error("outputs active in reset");
   a_lamp_amber_off: assert property (cnt < LAMP_TEST_CYC |->
      !port_amber_o && !health_amber_o) else $error("amber in lamp test");
   a_dark_no_link: assert property (live && !link_up_i[0] |=>
      !port_green_o[0] && !port_amber_o[0]) else $error("unlinked lit");
   a_fast_no_amber: assert property (live && forwarding_i[1] |=>
      !port_amber_o[1]) else $error("forwarding port amber");
   a_fault_amber: assert property (live && (over_temp_i || volt_fault_i ||
      mgmt_timeout_i) |=> health_amber_o && !health_green_o)
      else $error("fault not amber");
   a_safe_needs_eject: assert property (live && !ejector_partial_i ##1
      !ejector_partial_i |=> !hotswap_blue_o) else $error("blue latched");
endmodule // front_panel_led_checker
bind front_panel_led front_panel_led_checker #(
   .LAMP_TEST_CYC(LAMP_TEST_CYC)) chk_u (.*);

// [panel_led_defs.vh]
// Constants for the front-panel indicator block
`ifndef PANEL_LED_DEFS_VH
`define PANEL_LED_DEFS_VH
// Register byte offsets
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_IRQ_STAT    12'h008
`define REG_IRQ_MASK    12'h00c
`define REG_PORT_FWD    12'h010
// Control register fields
`define CTRL_MODE_BIT   0
`define CTRL_READY_BIT  1
// Interrupt status fields
`define IRQ_MODE_BIT    0
`define IRQ_REMOVE_BIT  1
`define IRQ_FAULT_BIT   2
`define IRQ_SAFE_BIT    3
`define IRQ_WIDTH       4
// Reset values
`define CTRL_RESET      2'b00
`define IRQ_MASK_RESET  4'h0
// Timing, in the unit named
`define CLK_MHZ         200
`define DEBOUNCE_MS     10
`define BLINK_MS        100
`define SELFTEST_BLINK_MS 250
`define LAMP_TEST_MS    500
`define STP_HOLD_S      30
`define DEBOUNCE_CYC    (`DEBOUNCE_MS * 1000 * `CLK_MHZ)
`define BLINK_CYC       (`BLINK_MS * 1000 * `CLK_MHZ)
`define SELFTEST_CYC    (`SELFTEST_BLINK_MS * 1000 * `CLK_MHZ)
`define LAMP_TEST_CYC   (`LAMP_TEST_MS * 1000 * `CLK_MHZ)
`define STP_HOLD_CYC    (64'd`STP_HOLD_S * 64'd1000000 * `CLK_MHZ)
// Speed codes per port
`define SPD_10          2'b00
`define SPD_100         2'b01
`define SPD_1000        2'b10
`endif

// [panel_operator.sv]
// Operator model: push-button with contact bounce
`timescale 1ns/100ps
module panel_operator #(
   parameter HOLD = 12
) (
   input  wire logic clk_i,
   input  wire logic press_i,
   output logic      button_o
);
   int cnt = 0;
   initial button_o = 1'b0;
   // Contacts chatter for four cycles before settling high
   always @(posedge clk_i) begin
      if (press_i)
         cnt <= HOLD + 4;
      else if (cnt > 0)
         cnt <= cnt - 1;
      button_o <= (cnt > HOLD) ? cnt[0] : (cnt > 0);
   end
endmodule // panel_operator

// [tb_front_panel_led.sv]
// Self-checking bench for the front-panel indicator block
`timescale 1ns/100ps
`include "panel_led_defs.vh"
module tb_front_panel_led;
   logic        clk_sys_i, ce_i, srst_i, psel_i, penable_i, pwrite_i, e, press;
   logic        ejector_partial_i, shutdown_done_i;
   logic        over_temp_i, volt_fault_i, mgmt_timeout_i;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, q;
   logic [25:0] link_up_i, activity_i, forwarding_i, reconfig_i;
   logic [51:0] speed_i;
   logic [3:0]  acc;
   wire  [31:0] prdata_o;
   wire  [25:0] port_green_o, port_amber_o;
   wire         pready_o, pslverr_o, health_green_o, health_amber_o;
   wire         hotswap_blue_o, remove_req_o, irq_o, button_i;
   int          mismatches, checks_done, cyc;
   front_panel_led #(.DEBOUNCE_CYC(4), .BLINK_CYC(4), .SELFTEST_CYC(8),
      .LAMP_TEST_CYC(16), .STP_HOLD_CYC(20)) dut_u (.*);
   panel_operator op_u (.clk_i(clk_sys_i), .press_i(press),
      .button_o(button_i));
   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   task report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // A hung handshake would stall the run, so cap it
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         report_and_stop;
      end
   end
   task chk(input string n, input logic [31:0] s, input logic [31:0] x);
      checks_done++;
      if (s !== x) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, x, s);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (pready_o !== 1'b1);
      q = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task lamp(input int p, input logic [1:0] x);
      repeat (3) @(posedge clk_sys_i);
      chk("lamp", {port_green_o[p], port_amber_o[p]}, x);
   endtask
   task press_btn;
      @(posedge clk_sys_i);
      press <= 1'b1;
      @(posedge clk_sys_i);
      press <= 1'b0;
      repeat (30) @(posedge clk_sys_i);
   endtask
   initial begin
      {ce_i, srst_i, cyc, mismatches, checks_done} = {2'h3, 96'h0};
      {psel_i, penable_i, pwrite_i, press, paddr_i, pwdata_i} = 0;
      {ejector_partial_i, shutdown_done_i} = 2'h0;
      {over_temp_i, volt_fault_i, mgmt_timeout_i} = 3'h0;
      link_up_i = 26'h300003e;
      activity_i = 26'h4;
      forwarding_i = 26'h3ffffef;
      reconfig_i = 26'h0;
      speed_i = {2'h1, 2'h2, 44'h0, 2'h1, 2'h0};
      repeat (8) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      acc = 0;
      repeat (14) @(posedge clk_sys_i) acc[0] |= hotswap_blue_o;
      chk("lamp_test", acc[0], 1);
      apb(0, `REG_STATUS, 0);
      chk("mode_reset", q[0], 0);
      apb(1, `REG_IRQ_MASK, 32'hf);
      apb(0, `REG_IRQ_MASK, 0);
      chk("irq_mask", q, 32'hf);
      apb(0, 12'h020, 0);
      chk("unmapped_err", e, 1);
      chk("unmapped_data", q, 0);
      repeat (20) @(posedge clk_sys_i);
      lamp(1, 2'h2);
      lamp(4, 2'h1);
      acc = 0;
      repeat (24) @(posedge clk_sys_i)
         acc |= {port_green_o[2], ~port_green_o[2],
                 health_green_o, ~health_green_o};
      chk("blinking", acc, 4'hf);
      apb(1, `REG_CTRL, 32'h2);
      acc = 0;
      repeat (16) @(posedge clk_sys_i) acc[0] |= ~health_green_o;
      chk("health_ready", acc[0], 0);
      reconfig_i <= 26'h8;
      @(posedge clk_sys_i);
      reconfig_i <= 26'h0;
      repeat (24) @(posedge clk_sys_i);
      lamp(3, 2'h2);
      apb(1, `REG_PORT_FWD, 32'h20);
      lamp(5, 2'h1);
      apb(0, `REG_IRQ_STAT, 0);
      press_btn;
      chk("irq_set", irq_o, 1);
      apb(0, `REG_IRQ_STAT, 0);
      chk("irq_stat", q[3:0], 4'h1);
      chk("irq_clear", irq_o, 0);
      apb(0, `REG_STATUS, 0);
      chk("mode_speed", q[0], 1);
      lamp(2, 2'h0);
      lamp(1, 2'h2);
      lamp(24, 2'h1);
      lamp(25, 2'h2);
      press_btn;
      apb(0, `REG_STATUS, 0);
      chk("mode_back", q[0], 0);
      for (int i = 0; i < 3; i++) begin
         {over_temp_i, volt_fault_i, mgmt_timeout_i} <= 3'h4 >> i;
         repeat (3) @(posedge clk_sys_i);
         chk("health", {health_green_o, health_amber_o}, 2'h1);
         {over_temp_i, volt_fault_i, mgmt_timeout_i} <= 3'h0;
         @(posedge clk_sys_i);
      end
      ejector_partial_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      chk("remove_req", {remove_req_o, hotswap_blue_o}, 2'h2);
      shutdown_done_i <= 1'b1;
      for (int i = 0; i < 20 && hotswap_blue_o !== 1'b1; i++)
         @(posedge clk_sys_i);
      chk("blue_safe", hotswap_blue_o, 1);
      ejector_partial_i <= 1'b0;
      shutdown_done_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      chk("blue_off", hotswap_blue_o, 0);
      report_and_stop;
   end
endmodule // tb_front_panel_led
